// file: logic/svaf_align_format.sv
// Receive video path: NRZI decode, descramble, word align, reformat and output.
// Assumes serial bits arrive from a recovery block as data plus a toggling strobe,
// and that control inputs come from logic on this clock.
`timescale 1ns/10ps

// How it works
// - incoming bits are NRZI decoded, then descrambled, before any sync search.
// - lock only after two timing references are found at one bit offset.
// - timing references are found in both the 10-bit and the 8-bit form.
// - HD output is one 10-bit word stream, chroma and luma interleaved.
// - 3G output carries two words per pixel clock, one on each edge.
// - 74.25 MHz luma and chroma are multiplexed onto the bus at twice the rate.
// - 1080i lines use blanking 560 and total 4400, or 1440 and 5280 at 50 Hz.
// - 1080p uses 560/4400, 1440/5280, or 1660/5500 at 24 Hz.
// - 720p blanking starts at sample 2560; totals 7920, 6600, 3960, 3300.
// - by default both copies of each timing reference pass to the output.
// - single reference mode blanks second reference, line number and CRC words.
// - ancillary data after the inserted blanking passes through untouched.
// - in 3G, one stream carries luma and the other interleaved chroma.
// - for 8-bit video the two lowest bits of each word are zero.
// - coded input at 1.001 times nominal rate is accepted unchanged.
// - coded input is replaced by decoded HD or 3G words before output.
// - the coded stream keeps standard definition timing and sync words.
// - encode plus decode latency stays within about 12 to 14 lines.
// - HD words change with the rising clock and hold for both edges; 3G puts different words on the two edges.
module svaf_align_format #(
  parameter int LOSS_BITS = svaf_pkg::LOSS_BITS_DEFAULT,
  parameter int FIFO_DEPTH = svaf_pkg::FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic serial_data_in,
  input wire logic serial_strobe_in,
  input wire logic [3:0] video_format,
  input wire logic is_three_g,
  input wire logic single_trs_output_select,
  input wire logic eight_bit_mode,
  input wire logic coded_input,
  input wire logic decoded_valid,
  input wire logic [9:0] decoded_word,
  input wire logic out_ready,
  output logic [9:0] parallel_video_out,
  output logic [9:0] parallel_video_out_fall,
  output logic [9:0] luma_stream,
  output logic [9:0] chroma_stream,
  output logic pixel_strobe,
  output logic ddr_mode,
  output logic h_blank_out,
  output logic aligned,
  output logic line_length_error,
  output logic fifo_overrun
);
  localparam int GAP_W = $clog2(LOSS_BITS + 1);
  localparam int W = svaf_pkg::WORD_W;
  localparam int D = svaf_pkg::TRS_DELAY;

  generate
    if (LOSS_BITS < svaf_pkg::BITS_PER_WORD * 3) begin : g_bad_loss
      $error("LOSS_BITS must cover at least one timing reference");
    end
  endgenerate

  // The 8-bit form needs its low bits clear, else first words 3fd and 3fe would match as headers too.
  function automatic logic ref_found(input logic [29:0] win);
    logic ten_bit;
    logic eight_bit;
    ten_bit = (win[9:0] == svaf_pkg::TRS_FIRST) && (win[19:10] == svaf_pkg::TRS_ZERO)
      && (win[29:20] == svaf_pkg::TRS_ZERO);
    eight_bit = (win[9:2] == svaf_pkg::TRS8_FIRST) && (win[1:0] == 2'h0)
      && (win[19:10] == svaf_pkg::TRS_ZERO) && (win[29:20] == svaf_pkg::TRS_ZERO);
    ref_found = ten_bit || eight_bit;
  endfunction : ref_found

  // Returns {first blanking word, line total} for the selected format.
  function automatic logic [31:0] line_timing(input svaf_pkg::svaf_format_t fmt);
    logic [31:0] t;
    t = {svaf_pkg::TOTAL_1080_60 - svaf_pkg::BLANK_1080_60, svaf_pkg::TOTAL_1080_60};
    case (fmt)
      svaf_pkg::SVAF_1080I_60, svaf_pkg::SVAF_1080P_60: begin
        t = {svaf_pkg::TOTAL_1080_60 - svaf_pkg::BLANK_1080_60, svaf_pkg::TOTAL_1080_60};
      end
      svaf_pkg::SVAF_1080I_50, svaf_pkg::SVAF_1080P_50: begin
        t = {svaf_pkg::TOTAL_1080_50 - svaf_pkg::BLANK_1080_50, svaf_pkg::TOTAL_1080_50};
      end
      svaf_pkg::SVAF_1080P_24: begin
        t = {svaf_pkg::TOTAL_1080_24 - svaf_pkg::BLANK_1080_24, svaf_pkg::TOTAL_1080_24};
      end
      svaf_pkg::SVAF_720P_25: begin
        t = {svaf_pkg::H_RISE_720, svaf_pkg::TOTAL_720_25};
      end
      svaf_pkg::SVAF_720P_30: begin
        t = {svaf_pkg::H_RISE_720, svaf_pkg::TOTAL_720_30};
      end
      svaf_pkg::SVAF_720P_50: begin
        t = {svaf_pkg::H_RISE_720, svaf_pkg::TOTAL_720_50};
      end
      svaf_pkg::SVAF_720P_60: begin
        t = {svaf_pkg::H_RISE_720, svaf_pkg::TOTAL_720_60};
      end
      default: begin
        t = {svaf_pkg::TOTAL_1080_60 - svaf_pkg::BLANK_1080_60, svaf_pkg::TOTAL_1080_60};
      end
    endcase
    line_timing = t;
  endfunction : line_timing

  // Clears the low bits for 8-bit video.
  function automatic logic [9:0] justify(input logic [9:0] w, input logic eight);
    justify = eight ? {w[9:svaf_pkg::LOW_BITS], {svaf_pkg::LOW_BITS{1'b0}}} : w;
  endfunction : justify

  // Pin synchronisers; the first stage feeds only the second.
  logic data_meta_q;
  logic data_sync_q;
  logic strobe_meta_q;
  logic strobe_sync_q;
  logic strobe_prev_q;
  logic bit_stb;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      data_meta_q <= 1'b0;
      data_sync_q <= 1'b0;
      strobe_meta_q <= 1'b0;
      strobe_sync_q <= 1'b0;
      strobe_prev_q <= 1'b0;
    end else begin
      data_meta_q <= serial_data_in;
      data_sync_q <= data_meta_q;
      strobe_meta_q <= serial_strobe_in;
      strobe_sync_q <= strobe_meta_q;
      strobe_prev_q <= strobe_sync_q;
    end
  end

  // Each strobe edge marks one new bit; the line rate itself does not matter here.
  assign bit_stb = strobe_sync_q ^ strobe_prev_q;

  logic nrzi_prev_q;
  logic [svaf_pkg::SCR_LEN-1:0] scr_q;
  logic nrz_bit;
  logic plain_bit;
  logic [29:0] win_q;
  logic [3:0] bit_cnt_q;
  logic fresh_q;

  assign nrz_bit = data_sync_q ^ nrzi_prev_q;
  assign plain_bit = nrz_bit ^ scr_q[svaf_pkg::SCR_TAP_A] ^ scr_q[svaf_pkg::SCR_TAP_B];

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      nrzi_prev_q <= 1'b0;
      scr_q <= '0;
      win_q <= '0;
      bit_cnt_q <= '0;
      fresh_q <= 1'b0;
    end else begin
      fresh_q <= bit_stb;
      if (bit_stb) begin
        nrzi_prev_q <= data_sync_q;
        scr_q <= {scr_q[svaf_pkg::SCR_LEN-2:0], nrz_bit};
        win_q <= {plain_bit, win_q[29:1]};
        if (bit_cnt_q == 4'(svaf_pkg::BITS_PER_WORD - 1)) begin
          bit_cnt_q <= '0;
        end else begin
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
      end
    end
  end

  // Alignment search; the SD-timed coded stream carries the same sync words.
  svaf_pkg::svaf_align_t align_q;
  logic [3:0] cand_q;
  logic [3:0] phase_q;
  logic [GAP_W-1:0] gap_q;
  logic ref_hit;
  logic gap_out;
  logic word_stb;

  assign ref_hit = fresh_q && ref_found(win_q);
  assign gap_out = (gap_q == GAP_W'(LOSS_BITS));
  assign word_stb = fresh_q && (align_q == svaf_pkg::ALIGN_LOCKED) && (bit_cnt_q == phase_q);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gap_q <= '0;
    end else if (ref_hit || align_q == svaf_pkg::ALIGN_SEARCH) begin
      gap_q <= '0;
    end else if (fresh_q && !gap_out) begin
      gap_q <= gap_q + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      align_q <= svaf_pkg::ALIGN_SEARCH;
      cand_q <= '0;
      phase_q <= '0;
      aligned <= 1'b0;
    end else begin
      case (align_q)
        svaf_pkg::ALIGN_SEARCH: begin
          if (ref_hit) begin
            cand_q <= bit_cnt_q;
            align_q <= svaf_pkg::ALIGN_CANDIDATE;
          end
        end
        svaf_pkg::ALIGN_CANDIDATE: begin
          if (ref_hit && bit_cnt_q == cand_q) begin
            phase_q <= bit_cnt_q;
            align_q <= svaf_pkg::ALIGN_LOCKED;
          end else if (ref_hit) begin
            cand_q <= bit_cnt_q;
          end else if (gap_out) begin
            align_q <= svaf_pkg::ALIGN_SEARCH;
          end
        end
        svaf_pkg::ALIGN_LOCKED: begin
          if ((ref_hit && bit_cnt_q != phase_q) || gap_out) begin
            align_q <= svaf_pkg::ALIGN_SEARCH;
          end
        end
        default: begin
          align_q <= svaf_pkg::ALIGN_SEARCH;
        end
      endcase
      aligned <= (align_q == svaf_pkg::ALIGN_LOCKED);
    end
  end

  // Source words: aligned words, or decoded words while the input is coded.
  logic src_stb;
  logic [W-1:0] src_word;

  assign src_stb = coded_input ? decoded_valid : word_stb;
  assign src_word = coded_input ? decoded_word : win_q[29:20];

  // Track the position of each word inside a timing reference.
  logic [W-1:0] hist1_q;
  logic [W-1:0] hist2_q;
  logic [3:0] pos_q;
  logic pos_act_q;
  logic eav_q;
  logic word_ref;

  assign word_ref = ref_found({src_word, hist1_q, hist2_q});

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hist1_q <= '0;
      hist2_q <= '0;
      pos_q <= '0;
      pos_act_q <= 1'b0;
      eav_q <= 1'b0;
    end else if (src_stb) begin
      hist1_q <= src_word;
      hist2_q <= hist1_q;
      if (word_ref) begin
        pos_q <= svaf_pkg::POS_AFTER_MATCH;
        pos_act_q <= 1'b1;
      end else if (pos_act_q) begin
        pos_q <= pos_q + 4'h1;
        if (pos_q == svaf_pkg::POS_LAST) begin
          pos_act_q <= 1'b0;
        end
      end
      if (pos_act_q && pos_q == svaf_pkg::POS_XYZ) begin
        eav_q <= src_word[svaf_pkg::XYZ_H_BIT];
      end
    end
  end

  // Eight words of delay let the late reference word move forward over the copy.
  logic [W-1:0] dly_q [D];
  logic [D-1:0] fill_q;
  logic single_mode;
  logic in_second;
  logic in_line_words;
  logic [W-1:0] blank_word;
  logic [W-1:0] dly_in;

  assign single_mode = single_trs_output_select;
  assign in_second = pos_act_q && pos_q >= svaf_pkg::POS_AFTER_MATCH
    && pos_q <= svaf_pkg::POS_SECOND_END;
  assign in_line_words = pos_act_q && pos_q > svaf_pkg::POS_SECOND_END && eav_q;
  assign blank_word = pos_q[0] ? svaf_pkg::BLANK_LUMA : svaf_pkg::BLANK_CHROMA;

  always_comb begin
    dly_in = src_word;
    if (single_mode && (in_second || in_line_words)) begin
      dly_in = blank_word;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fill_q <= '0;
      for (int i = 0; i < D; i++) begin
        dly_q[i] <= '0;
      end
    end else if (src_stb) begin
      fill_q <= {fill_q[D-2:0], 1'b1};
      dly_q[0] <= dly_in;
      for (int i = 1; i < D; i++) begin
        dly_q[i] <= dly_q[i-1];
      end
      // Words past the line CRC, ancillary data included, are never touched.
      if (single_mode && word_ref) begin
        dly_q[svaf_pkg::SLOT_FIRST] <= svaf_pkg::TRS_FIRST;
        dly_q[svaf_pkg::SLOT_SECOND] <= svaf_pkg::TRS_ZERO;
        dly_q[svaf_pkg::SLOT_THIRD] <= svaf_pkg::TRS_ZERO;
      end
      if (single_mode && pos_act_q && pos_q == svaf_pkg::POS_XYZ) begin
        dly_q[svaf_pkg::SLOT_XYZ] <= src_word;
      end
    end
  end

  // The FIFO absorbs short output stalls; the serial side cannot wait.
  svaf_word_if #(.W(W)) fill_if ();
  svaf_word_if #(.W(W)) drain_if ();

  assign fill_if.valid = src_stb && fill_q[D-1];
  assign fill_if.data = dly_q[D-1];

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fifo_overrun <= 1'b0;
    end else if (fill_if.valid && !fill_if.ready) begin
      fifo_overrun <= 1'b1;
    end
  end

  svaf_fifo #(.W(W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rst_b(rst_b),
    .wr(fill_if.sink),
    .rd(drain_if.source)
  );

  // Output stage: HD emits each word; 3G pairs chroma then luma for the two edges.
  logic pop;
  logic pair_q;
  logic [W-1:0] held_q;
  logic [W-1:0] pop_word;

  assign drain_if.ready = out_ready;
  assign pop = drain_if.valid && out_ready;
  assign pop_word = justify(drain_if.data, eight_bit_mode);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pair_q <= 1'b0;
      held_q <= '0;
      parallel_video_out <= '0;
      parallel_video_out_fall <= '0;
      luma_stream <= '0;
      chroma_stream <= '0;
      pixel_strobe <= 1'b0;
      ddr_mode <= 1'b0;
    end else begin
      ddr_mode <= is_three_g;
      pixel_strobe <= 1'b0;
      if (pop) begin
        pair_q <= !pair_q;
        held_q <= pop_word;
        if (!is_three_g) begin
          parallel_video_out <= pop_word;
          parallel_video_out_fall <= pop_word;
          pixel_strobe <= 1'b1;
        end else if (pair_q) begin
          parallel_video_out <= held_q;
          parallel_video_out_fall <= pop_word;
          pixel_strobe <= 1'b1;
        end
        if (pair_q) begin
          chroma_stream <= held_q;
          luma_stream <= pop_word;
        end
      end
    end
  end

  // Line timing from the words actually leaving the block.
  logic [W-1:0] out1_q;
  logic [W-1:0] out2_q;
  logic hunt_q;
  logic [15:0] line_cnt_q;
  logic line_seen_q;
  logic [31:0] timing;

  assign timing = line_timing(svaf_pkg::svaf_format_t'(video_format));

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      out1_q <= '0;
      out2_q <= '0;
      hunt_q <= 1'b0;
      line_cnt_q <= '0;
      line_seen_q <= 1'b0;
      h_blank_out <= 1'b1;
      line_length_error <= 1'b0;
    end else begin
      line_length_error <= 1'b0;
      if (pop) begin
        out1_q <= drain_if.data;
        out2_q <= out1_q;
        if (line_cnt_q != 16'hffff) begin
          line_cnt_q <= line_cnt_q + 16'h0001;
        end
        if (ref_found({drain_if.data, out1_q, out2_q})) begin
          hunt_q <= 1'b1;
        end else if (hunt_q && drain_if.data[svaf_pkg::XYZ_MARK_BIT]) begin
          hunt_q <= 1'b0;
          if (!drain_if.data[svaf_pkg::XYZ_H_BIT]) begin
            line_cnt_q <= '0;
            line_seen_q <= 1'b1;
            if (line_seen_q && (line_cnt_q + 16'h0001) != timing[15:0]) begin
              line_length_error <= 1'b1;
            end
          end
        end
        h_blank_out <= (line_cnt_q >= timing[31:16]);
      end
    end
  end

endmodule : svaf_align_format

// file: logic/svaf_fifo.sv
// Word FIFO with parameterised width and depth, flip-flop storage.
// Assumes one clock; the reader may stall and the FIFO then fills.
`timescale 1ns/10ps
module svaf_fifo #(
  parameter int W = 10,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst_b,
  svaf_word_if.sink wr,
  svaf_word_if.source rd
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("svaf_fifo depth must be a power of two of at least two");
    end
  endgenerate

  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;
  logic full;
  logic empty;

  // One extra pointer bit tells full from empty without a counter.
  assign empty = (wr_ptr_q == rd_ptr_q);
  assign full = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data = mem_q[rd_ptr_q[AW-1:0]];

  always_ff @(posedge clock) begin
    if (wr.valid && !full) begin
      mem_q[wr_ptr_q[AW-1:0]] <= wr.data;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (wr.valid && !full) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (rd.ready && !empty) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

endmodule : svaf_fifo

// file: logic/svaf_pkg.sv
// Constants and types shared by the video align and format path.
// Assumes a single 100 MHz clock domain for every user of these names.
package svaf_pkg;

  localparam int WORD_W = 10;
  localparam int BITS_PER_WORD = 10;
  localparam int FIFO_DEPTH = 16;

  // Timing reference words in their 10-bit and 8-bit forms.
  localparam logic [9:0] TRS_FIRST = 10'h3ff;
  localparam logic [9:0] TRS_ZERO = 10'h000;
  localparam logic [7:0] TRS8_FIRST = 8'hff;

  // Blanking levels inserted in single timing reference mode.
  localparam logic [9:0] BLANK_CHROMA = 10'h200;
  localparam logic [9:0] BLANK_LUMA = 10'h040;

  // Descrambler taps for x^9 + x^4 + 1 on the history of NRZ bits.
  localparam int SCR_LEN = 9;
  localparam int SCR_TAP_A = 3;
  localparam int SCR_TAP_B = 8;

  // Word positions counted from the first word of a timing reference.
  localparam int TRS_DELAY = 8;
  localparam logic [3:0] POS_AFTER_MATCH = 4'h4;
  localparam logic [3:0] POS_XYZ = 4'h6;
  localparam logic [3:0] POS_SECOND_END = 4'h7;
  localparam logic [3:0] POS_LAST = 4'hf;
  localparam int SLOT_FIRST = 3;
  localparam int SLOT_SECOND = 2;
  localparam int SLOT_THIRD = 1;
  localparam int SLOT_XYZ = 3;
  localparam int XYZ_MARK_BIT = 9;
  localparam int XYZ_H_BIT = 6;
  localparam int LOW_BITS = 2;

  // Horizontal blanking and line totals, in multiplexed words.
  localparam logic [15:0] BLANK_1080_60 = 16'h0230;
  localparam logic [15:0] TOTAL_1080_60 = 16'h1130;
  localparam logic [15:0] BLANK_1080_50 = 16'h05a0;
  localparam logic [15:0] TOTAL_1080_50 = 16'h14a0;
  localparam logic [15:0] BLANK_1080_24 = 16'h067c;
  localparam logic [15:0] TOTAL_1080_24 = 16'h157c;
  localparam logic [15:0] H_RISE_720 = 16'h0a00;
  localparam logic [15:0] TOTAL_720_25 = 16'h1ef0;
  localparam logic [15:0] TOTAL_720_30 = 16'h19c8;
  localparam logic [15:0] TOTAL_720_50 = 16'h0f78;
  localparam logic [15:0] TOTAL_720_60 = 16'h0ce4;

  // Longest line is the 720p25 total; alignment is dropped after this many bits.
  localparam int LOSS_BITS_DEFAULT = 79200;

  // Coded streams must be decoded within this many output lines.
  localparam int LATENCY_LINES_MAX = 14;

  typedef enum logic [3:0] {
    SVAF_1080I_60,
    SVAF_1080I_50,
    SVAF_1080P_60,
    SVAF_1080P_50,
    SVAF_1080P_24,
    SVAF_720P_25,
    SVAF_720P_30,
    SVAF_720P_50,
    SVAF_720P_60
  } svaf_format_t;

  typedef enum logic [1:0] {
    ALIGN_SEARCH,
    ALIGN_CANDIDATE,
    ALIGN_LOCKED
  } svaf_align_t;

endpackage : svaf_pkg

// file: logic/svaf_word_if.sv
// Valid and ready word channel between the aligner and the output FIFO.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface svaf_word_if #(parameter int W = 10) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface : svaf_word_if

// file: verif/svaf_align_format_asserts.sv
// Concurrent checks on the ports of the video align and format top module.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/10ps
module svaf_align_format_asserts #(
  parameter int LOSS_BITS = 600,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic eight_bit_mode,
  input wire logic out_ready,
  input wire logic [9:0] parallel_video_out,
  input wire logic [9:0] parallel_video_out_fall,
  input wire logic [9:0] luma_stream,
  input wire logic [9:0] chroma_stream,
  input wire logic pixel_strobe,
  input wire logic ddr_mode,
  input wire logic h_blank_out,
  input wire logic aligned,
  input wire logic line_length_error,
  input wire logic fifo_overrun
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  pair_map_a: assert property (pixel_strobe && ddr_mode |->
    chroma_stream == parallel_video_out && luma_stream == parallel_video_out_fall)
    else $error("paired words not copied to the two streams");
  hd_both_a: assert property (pixel_strobe && !ddr_mode |->
    parallel_video_out_fall == parallel_video_out) else $error("single rate words differ");
  eight_low_a: assert property (pixel_strobe && eight_bit_mode && $past(eight_bit_mode, 2) |->
    parallel_video_out[1:0] == 2'b00 && parallel_video_out_fall[1:0] == 2'b00)
    else $error("low bits set in eight bit mode");
  ddr_gap_a: assert property (pixel_strobe && ddr_mode |=> !pixel_strobe)
    else $error("paired output on consecutive cycles");
  out_stall_a: assert property (!out_ready |=> !pixel_strobe)
    else $error("output updated during stall");
  word_hold_a: assert property (!pixel_strobe |->
    $stable(parallel_video_out) && $stable(parallel_video_out_fall))
    else $error("output word changed without strobe");
  blank_on_pop_a: assert property ($changed(h_blank_out) |-> $past(out_ready))
    else $error("blanking flag moved without a word");
  err_pulse_a: assert property (line_length_error |=> !line_length_error)
    else $error("line length flag longer than one cycle");

  cover property ($rose(aligned));
  cover property ($rose(fifo_overrun));
  cover property (line_length_error);
  cover property (pixel_strobe && ddr_mode);
endmodule : svaf_align_format_asserts

bind svaf_align_format svaf_align_format_asserts #(.LOSS_BITS(LOSS_BITS),
  .FIFO_DEPTH(FIFO_DEPTH)) i_chk (.clock(clock), .rst_b(rst_b),
  .eight_bit_mode(eight_bit_mode), .out_ready(out_ready),
  .parallel_video_out(parallel_video_out), .parallel_video_out_fall(parallel_video_out_fall),
  .luma_stream(luma_stream), .chroma_stream(chroma_stream), .pixel_strobe(pixel_strobe),
  .ddr_mode(ddr_mode), .h_blank_out(h_blank_out), .aligned(aligned),
  .line_length_error(line_length_error), .fifo_overrun(fifo_overrun));

// file: verif/svaf_sink_model.sv
// Downstream capture model: drives ready with optional stalls and collects words.
// Assumes the DUT marks each output update with a one-cycle strobe.
`timescale 1ns/10ps
module svaf_sink_model (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic stall_en,
  input wire logic hold,
  input wire logic pixel_strobe,
  input wire logic ddr_mode,
  input wire logic [9:0] parallel_video_out,
  input wire logic [9:0] parallel_video_out_fall,
  output logic out_ready
);
  logic [9:0] got[$];
  logic [1:0] phase_q;
  // Stalls every third cycle so the FIFO sees back pressure in ordinary runs.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= 2'd0;
      out_ready <= 1'b0;
    end else begin
      phase_q <= (phase_q == 2'd2) ? 2'd0 : phase_q + 2'd1;
      out_ready <= !hold && !(stall_en && phase_q == 2'd2);
    end
  end
  // A paired update carries two words: the rise word first, then the fall word.
  always @(posedge clock) begin
    if (pixel_strobe === 1'b1) begin
      got.push_back(parallel_video_out);
      if (ddr_mode === 1'b1) got.push_back(parallel_video_out_fall);
    end
  end
endmodule : svaf_sink_model

// file: verif/testbench.sv
// Self-checking bench for the video align and format path.
// Assumes the DUT, its FIFO, the sink model and the bound checker are compiled first.
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module testbench;
  logic clock = 0, rst_b = 0, serial_data_in = 0, serial_strobe_in = 0;
  logic [3:0] video_format = 4'h0;
  logic is_three_g = 0, single_trs_output_select = 0, eight_bit_mode = 0, coded_input = 1;
  logic decoded_valid = 0, stall_en = 1, hold = 0, out_ready, lvl = 0;
  logic [9:0] decoded_word = 10'h000;
  logic [9:0] parallel_video_out, parallel_video_out_fall, luma_stream, chroma_stream;
  logic pixel_strobe, ddr_mode, h_blank_out, aligned, line_length_error, fifo_overrun;
  logic [8:0] hist = 9'h000;
  int failures = 0, check_count = 0, errcnt = 0, sc = 0, bc = 0, lim = 0;
  int tot[9] = '{4400, 5280, 4400, 5280, 5500, 7920, 6600, 3960, 3300};
  int bl[5] = '{560, 1440, 560, 1440, 1660};

  always #5 clock = ~clock;

  svaf_align_format #(.LOSS_BITS(600), .FIFO_DEPTH(16)) i_dut (.clock(clock), .rst_b(rst_b),
    .serial_data_in(serial_data_in), .serial_strobe_in(serial_strobe_in),
    .video_format(video_format), .is_three_g(is_three_g),
    .single_trs_output_select(single_trs_output_select), .eight_bit_mode(eight_bit_mode),
    .coded_input(coded_input), .decoded_valid(decoded_valid), .decoded_word(decoded_word),
    .out_ready(out_ready), .parallel_video_out(parallel_video_out),
    .parallel_video_out_fall(parallel_video_out_fall), .luma_stream(luma_stream),
    .chroma_stream(chroma_stream), .pixel_strobe(pixel_strobe), .ddr_mode(ddr_mode),
    .h_blank_out(h_blank_out), .aligned(aligned), .line_length_error(line_length_error),
    .fifo_overrun(fifo_overrun));
  svaf_sink_model i_sink (.clock(clock), .rst_b(rst_b), .stall_en(stall_en), .hold(hold),
    .pixel_strobe(pixel_strobe), .ddr_mode(ddr_mode), .parallel_video_out(parallel_video_out),
    .parallel_video_out_fall(parallel_video_out_fall), .out_ready(out_ready));

  always @(posedge clock) begin
    if (line_length_error === 1'b1) errcnt++;
    if (pixel_strobe === 1'b1 && sc < lim) begin
      sc++;
      if (h_blank_out === 1'b1) bc++;
    end
  end

  task automatic conclude;
    if (failures == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  task automatic reset_dut;
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    i_sink.got.delete();
  endtask : reset_dut

  task automatic feed(input logic [9:0] w);
    @(posedge clock);
    decoded_valid <= 1'b1;
    decoded_word <= w;
    @(posedge clock);
    decoded_valid <= 1'b0;
  endtask : feed

  // Scrambles with x^9+x^4+1, then codes NRZI: a one toggles the line level.
  task automatic sbit(input logic b);
    logic s;
    s = b ^ hist[svaf_pkg::SCR_TAP_A] ^ hist[svaf_pkg::SCR_TAP_B];
    hist = {hist[7:0], s};
    lvl = lvl ^ s;
    @(posedge clock);
    serial_data_in <= lvl;
    @(posedge clock);
    serial_strobe_in <= ~serial_strobe_in;
    repeat (2) @(posedge clock);
  endtask : sbit

  task automatic sword(input logic [9:0] w);
    for (int i = 0; i < 10; i++) sbit(w[i]);
  endtask : sword

  task automatic sref(input logic [9:0] f);
    sword(f); sword(f);
    repeat (4) sword(10'h000);
    sword(10'h274); sword(10'h274);
    repeat (4) sword(10'h200);
  endtask : sref

  task automatic serial_lock(input logic [9:0] f);
    coded_input <= 1'b0;
    reset_dut();
    repeat (3) sword(10'h200);
    sref(f);
    `CHK("aligned after one", 1'b0, aligned)
    sref(f);
    `CHK("aligned after two", 1'b1, aligned)
    sbit(1'b0);
    sref(f);
    `CHK("aligned after shift", 1'b0, aligned)
    sref(f);
    sref(f);
    `CHK("realigned", 1'b1, aligned)
    coded_input <= 1'b1;
  endtask : serial_lock

  task automatic run_words(input logic tg, input logic sg, input logic eb);
    logic [9:0] w[28], e;
    is_three_g <= tg;
    single_trs_output_select <= sg;
    eight_bit_mode <= eb;
    reset_dut();
    for (int i = 0; i < 28; i++) begin
      w[i] = i < 2 ? 10'h3ff : i < 6 ? 10'h000 : i < 8 ? 10'h274 : i < 16 ? 10'h155 + i :
        i == 16 ? 10'h000 : i < 19 ? 10'h3ff : 10'h2ab ^ i;
      feed(w[i]);
    end
    repeat (60) @(posedge clock);
    `CHK("word count", 20, i_sink.got.size())
    for (int i = 0; i < 20; i++) begin
      e = !sg || i > 15 ? w[i] : i == 0 ? 10'h3ff : i == 3 ? 10'h274 : i < 3 ? 10'h000 :
        (i % 2) ? svaf_pkg::BLANK_LUMA : svaf_pkg::BLANK_CHROMA;
      if (eb) e = e & 10'h3fc;
      `CHK("output word", e, i_sink.got[i])
    end
  endtask : run_words

  task automatic overrun;
    hold <= 1'b1;
    reset_dut();
    `CHK("overrun idle", 1'b0, fifo_overrun)
    for (int i = 0; i < 26; i++) feed(10'h100 + i);
    `CHK("overrun set", 1'b1, fifo_overrun)
    hold <= 1'b0;
    repeat (80) @(posedge clock);
    `CHK("drained", 16, i_sink.got.size())
  endtask : overrun

  task automatic send_line(input int n, input int clr);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      decoded_valid <= 1'b1;
      decoded_word <= i == 0 ? 10'h3ff : i < 3 ? 10'h000 : i == 3 ? 10'h280 : 10'h040;
      if (i == clr) #1 {errcnt, sc, bc} = 96'd0;
    end
    @(posedge clock);
    decoded_valid <= 1'b0;
  endtask : send_line

  task automatic line_fmt(input int f);
    video_format <= f[3:0];
    stall_en <= 1'b0;
    reset_dut();
    lim = tot[f];
    send_line(20, -1);
    send_line(tot[f], 30);
    send_line(40, -1);
    send_line(12, -1);
    repeat (30) @(posedge clock);
    `CHK("length flags", 1, errcnt)
    `CHK("blank words", f >= 5 ? tot[f] - 2560 : bl[f], bc)
  endtask : line_fmt

  initial begin
    repeat (90000) @(posedge clock);
    failures++;
    conclude();
  end

  initial begin
    reset_dut();
    serial_lock(10'h3ff);
    serial_lock(10'h3fc);
    run_words(1'b0, 1'b0, 1'b0);
    run_words(1'b0, 1'b1, 1'b0);
    run_words(1'b0, 1'b0, 1'b1);
    run_words(1'b1, 1'b1, 1'b1);
    is_three_g <= 1'b0;
    overrun();
    for (int f = 0; f < 9; f++) line_fmt(f);
    conclude();
  end
endmodule : testbench
